/* lcd_i2c_regs.vh */
`ifndef LCD_I2C_REGS_VH
`define LCD_I2C_REGS_VH
// bus address of the controller (7 bits)
`define LCD_SLAVE_ADDR   7'h3A
// control byte fields
`define LCD_CTRL_CONT    7
`define LCD_CTRL_RSEL    6
`define LCD_CTRL_RDWR    5
// instruction decode
`define LCD_INS_SETADDR  7
`define LCD_HOME_CODE    7'h01
`define LCD_SHIFT_CODE   5'h03
`define LCD_SHIFT_RIGHT  2
// storage sizes
`define LCD_RAM_DEPTH    128
`define LCD_AC_W         7
`define LCD_FIFO_DEPTH   32
`define LCD_FIFO_AW      5
`define LCD_FIFO_W       9
// reset values
`define LCD_AC_RST       7'h00
`define LCD_HOLD_RST     8'h00
`define LCD_OFFS_RST     7'h00
`endif

/* lcd_i2c.v */
// Summary of operation
// R1: return home clears address counter and display shift
// R2: return home keeps RAM and holding register
// R3: master sets select and read bits before reading
// R4: address acknowledge loads holding register for sending
// R5: unloaded holding register gives undefined first byte
// R6: master acknowledge loads next RAM location
// R7: read byte shifted out MSB first, eight clocks
// R8: missing master acknowledge causes no internal action
// R9: master ends read with no acknowledge, stop
// R10: controller releases data line during read acknowledge
// R11: master repeats start with read address
// R12: control byte latches select and read bits
// R13: instruction executes on acknowledge clock pulse
// R14: acknowledged data read advances the address counter
`timescale 1ns/1ns
`include "lcd_i2c_regs.vh"

module lcd_fifo #(
  parameter W  = 9,
  parameter D  = 32,
  parameter AW = 5
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg  [W-1:0] mem_reg [0:D-1];
  reg  [AW-1:0] wr_ptr_reg;
  reg  [AW-1:0] rd_ptr_reg;
  reg  [AW:0]   count_reg;
  wire          push;
  wire          pop;

  assign in_ready  = (count_reg != D[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module lcd_i2c (
  input  wire                 clk_sys,
  input  wire                 rst,
  input  wire                 scl_in,
  input  wire                 sda_in,
  output wire                 sda_out,
  output wire                 sda_oe,
  output wire                 cmd_valid,
  input  wire                 cmd_ready,
  output wire                 cmd_rs,
  output wire [7:0]           cmd_byte,
  output wire [`LCD_AC_W-1:0] addr_counter,
  output wire [`LCD_AC_W-1:0] disp_offset
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_AACK = 9'h004;
  localparam [8:0] S_CTRL = 9'h008;
  localparam [8:0] S_CACK = 9'h010;
  localparam [8:0] S_DATA = 9'h020;
  localparam [8:0] S_DACK = 9'h040;
  localparam [8:0] S_RD   = 9'h080;
  localparam [8:0] S_RACK = 9'h100;

  reg  [8:0]           state_reg;
  reg                  scl_q_reg;
  reg                  sda_q_reg;
  reg  [3:0]           cnt_reg;
  reg  [7:0]           rx_reg;
  reg  [7:0]           tx_reg;
  reg                  oe_reg;
  reg                  ack_reg;
  reg                  rd_dir_reg;
  reg                  cont_reg;
  reg                  rsel_reg;
  reg                  rdwr_reg;
  reg                  mack_reg;
  reg  [`LCD_AC_W-1:0] ac_reg;
  reg  [`LCD_AC_W-1:0] offs_reg;
  reg  [7:0]           hold_reg;
  reg  [7:0]           ram_reg [0:`LCD_RAM_DEPTH-1];
  reg                  push_reg;
  reg  [8:0]           push_data_reg;
  wire                 fifo_in_ready;
  wire [8:0]           fifo_out;
  wire                 scl_rise;
  wire                 scl_fall;
  wire                 start_det;
  wire                 stop_det;
  wire [7:0]           ram_at_ac;

  assign scl_rise  = scl_in & ~scl_q_reg;
  assign scl_fall  = ~scl_in & scl_q_reg;
  assign start_det = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_det  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
  assign ram_at_ac = ram_reg[ac_reg];

  assign sda_out      = 1'b0;
  assign sda_oe       = oe_reg;
  assign cmd_rs       = fifo_out[8];
  assign cmd_byte     = fifo_out[7:0];
  assign addr_counter = ac_reg;
  assign disp_offset  = offs_reg;

  lcd_fifo #(
    .W  (`LCD_FIFO_W),
    .D  (`LCD_FIFO_DEPTH),
    .AW (`LCD_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_reg),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (fifo_out)
  );

  // display text ram, written by data bytes
  always @(posedge clk_sys) begin
    if ((state_reg == S_DACK) && scl_rise && ack_reg && rsel_reg &&
        !rdwr_reg) begin
      ram_reg[ac_reg] <= rx_reg;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      scl_q_reg     <= 1'b1;
      sda_q_reg     <= 1'b1;
      cnt_reg       <= 4'h0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      oe_reg        <= 1'b0;
      ack_reg       <= 1'b0;
      rd_dir_reg    <= 1'b0;
      cont_reg      <= 1'b0;
      rsel_reg      <= 1'b0;
      rdwr_reg      <= 1'b0;
      mack_reg      <= 1'b0;
      ac_reg        <= `LCD_AC_RST;
      offs_reg      <= `LCD_OFFS_RST;
      hold_reg      <= `LCD_HOLD_RST;
      push_reg      <= 1'b0;
      push_data_reg <= 9'h000;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
      push_reg  <= 1'b0;
      if (stop_det) begin
        state_reg <= S_IDLE;
        oe_reg    <= 1'b0;
      end else if (start_det) begin
        state_reg <= S_ADDR;
        cnt_reg   <= 4'h0;
        oe_reg    <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            oe_reg <= 1'b0;
          end
          S_ADDR, S_CTRL, S_DATA: begin
            if (scl_rise) begin
              rx_reg  <= {rx_reg[6:0], sda_in};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              cnt_reg <= 4'h0;
              if (state_reg == S_ADDR) begin
                if (rx_reg[7:1] == `LCD_SLAVE_ADDR) begin
                  rd_dir_reg <= rx_reg[0];
                  ack_reg    <= 1'b1;
                  oe_reg     <= 1'b1;
                  state_reg  <= S_AACK;
                end else begin
                  state_reg  <= S_IDLE;
                end
              end else if (state_reg == S_CTRL) begin
                ack_reg   <= 1'b1;
                oe_reg    <= 1'b1;
                state_reg <= S_CACK;
              end else begin
                // a full command queue refuses the byte
                ack_reg   <= fifo_in_ready;
                oe_reg    <= fifo_in_ready;
                state_reg <= S_DACK;
              end
            end
          end
          S_AACK: begin
            if (scl_rise && rd_dir_reg) begin
              tx_reg <= rsel_reg ? hold_reg : {1'b0, ac_reg}; // R4 R5
            end else if (scl_fall) begin
              if (rd_dir_reg) begin
                oe_reg    <= ~tx_reg[7]; // R7
                state_reg <= S_RD;
              end else begin
                oe_reg    <= 1'b0;
                state_reg <= S_CTRL;
              end
            end
          end
          S_CACK: begin
            if (scl_rise) begin
              cont_reg <= rx_reg[`LCD_CTRL_CONT]; // R12
              rsel_reg <= rx_reg[`LCD_CTRL_RSEL]; // R12
              rdwr_reg <= rx_reg[`LCD_CTRL_RDWR]; // R12
            end else if (scl_fall) begin
              oe_reg    <= 1'b0;
              state_reg <= S_DATA;
            end
          end
          S_DACK: begin
            if (scl_rise && ack_reg) begin // R13
              push_reg      <= 1'b1;
              push_data_reg <= {rsel_reg, rx_reg};
              if (rsel_reg) begin
                if (!rdwr_reg) begin
                  ac_reg <= ac_reg + 1'b1;
                end
              end else if (rx_reg[`LCD_INS_SETADDR]) begin
                ac_reg   <= rx_reg[`LCD_AC_W-1:0];
                hold_reg <= ram_reg[rx_reg[`LCD_AC_W-1:0]];
              end else if (rx_reg[7:1] == `LCD_HOME_CODE) begin
                ac_reg   <= `LCD_AC_RST; // R1 R2
                offs_reg <= `LCD_OFFS_RST; // R1
              end else if (rx_reg[7:3] == `LCD_SHIFT_CODE) begin
                if (rx_reg[`LCD_SHIFT_RIGHT]) begin
                  offs_reg <= offs_reg + 1'b1;
                end else begin
                  offs_reg <= offs_reg - 1'b1;
                end
              end
            end else if (scl_fall) begin
              oe_reg    <= 1'b0;
              state_reg <= cont_reg ? S_CTRL : S_DATA;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                cnt_reg   <= 4'h0;
                oe_reg    <= 1'b0;
                state_reg <= S_RACK;
              end else begin
                cnt_reg <= cnt_reg + 4'h1;
                tx_reg  <= {tx_reg[6:0], 1'b0}; // R7
                oe_reg  <= ~tx_reg[6]; // R7
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_in;
              if (!sda_in) begin
                if (rsel_reg) begin
                  tx_reg   <= ram_at_ac; // R6
                  hold_reg <= ram_at_ac; // R6
                  ac_reg   <= ac_reg + 1'b1; // R14
                end else begin
                  tx_reg <= {1'b0, ac_reg};
                end
              end
            end else if (scl_fall) begin
              if (mack_reg) begin
                oe_reg    <= ~tx_reg[7]; // R7
                state_reg <= S_RD;
              end else begin
                oe_reg    <= 1'b0; // R8
                state_reg <= S_IDLE; // R8
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            oe_reg    <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

/* lcd_i2c_sva.sv */
`timescale 1ns/1ns
`include "lcd_i2c_regs.vh"
module lcd_i2c_sva (
  input wire                 clk_sys,
  input wire                 rst,
  input wire                 scl_in,
  input wire                 sda_in,
  input wire                 sda_out,
  input wire                 sda_oe,
  input wire                 cmd_valid,
  input wire                 cmd_ready,
  input wire                 cmd_rs,
  input wire [7:0]           cmd_byte,
  input wire [`LCD_AC_W-1:0] addr_counter,
  input wire [`LCD_AC_W-1:0] disp_offset
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // scl fall seen one edge back
  sequence fall_s;
    $past(scl_in, 2) && !$past(scl_in);
  endsequence
  // data edge while clock high
  sequence edge_s;
    $past(scl_in, 2) && $past(scl_in) && $past(sda_in) != $past(sda_in, 2);
  endsequence
  sequence stop_s;
    scl_in && $past(scl_in) && sda_in && !$past(sda_in);
  endsequence
  a_reset_values: assert property ($fell(rst) |-> !sda_oe && !cmd_valid
    && addr_counter == 0 && disp_offset == 0) else $error("reset values");
  a_oe_rise_fall: assert property ($rose(sda_oe) |-> fall_s)
    else $error("drive began off a clock fall");
  a_oe_cause: assert property ($changed(sda_oe) |-> fall_s or edge_s)
    else $error("drive changed without cause");
  a_stop_release: assert property (stop_s |=> !sda_oe [*8])
    else $error("drive after stop");
  a_ac_on_high: assert property ($changed(addr_counter) |->
    $past(scl_in) && !$past(scl_in, 2)) else $error("counter moved off ack");
  a_offset_step: assert property ($changed(disp_offset) |->
    disp_offset == $past(disp_offset) + 7'h01
    || disp_offset == $past(disp_offset) - 7'h01
    || (disp_offset == 0 && addr_counter == 0)) else $error("offset jump");
  a_head_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid
    && $stable(cmd_byte) && $stable(cmd_rs)) else $error("head changed");
  a_cmd_on_ack: assert property ($rose(cmd_valid) |->
    $past(scl_in) && $past(scl_in, 2)) else $error("queue push off ack");
endmodule
bind lcd_i2c lcd_i2c_sva i_lcd_i2c_sva (.clk_sys, .rst, .scl_in, .sda_in,
  .sda_out, .sda_oe, .cmd_valid, .cmd_ready, .cmd_rs, .cmd_byte,
  .addr_counter, .disp_offset);

/* lcd_i2c_mst.sv */
`timescale 1ns/1ns
module lcd_i2c_mst #(
  parameter H = 4
) (
  input  wire clk_sys,
  input  wire sda_in,
  output reg  scl,
  output reg  sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task wt;
    repeat (H) @(negedge clk_sys);
  endtask
  task bit_io(input b, output r);
    begin
      sda_m = b;
      wt;
      scl = 1'b1;
      wt;
      r = sda_in;
      scl = 1'b0;
      wt;
    end
  endtask
  task start;
    begin
      sda_m = 1'b1;
      wt;
      scl = 1'b1;
      wt;
      sda_m = 1'b0;
      wt;
      scl = 1'b0;
      wt;
    end
  endtask
  task stop;
    begin
      sda_m = 1'b0;
      wt;
      scl = 1'b1;
      wt;
      sda_m = 1'b1;
      wt;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task rbyte(input mack, output [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(1'b1, d[i]);
      bit_io(~mack, r);
    end
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ns
`include "lcd_i2c_regs.vh"
module tb_top;
  reg                  clk_sys;
  reg                  rst;
  reg                  cmd_ready;
  reg                  ack;
  reg  [7:0]           rd;
  wire                 scl;
  wire                 sda_m;
  wire                 sda_out;
  wire                 sda_oe;
  wire                 sda_w;
  wire                 cmd_valid;
  wire                 cmd_rs;
  wire [7:0]           cmd_byte;
  wire [`LCD_AC_W-1:0] addr_counter;
  wire [`LCD_AC_W-1:0] disp_offset;
  integer              miscompares;
  integer              n_compared;
  localparam [7:0] WADR = {`LCD_SLAVE_ADDR, 1'b0};
  localparam [7:0] RADR = {`LCD_SLAVE_ADDR, 1'b1};
  assign sda_w = sda_m & ~(sda_oe & ~sda_out);
  always #4 clk_sys = ~clk_sys;
  lcd_i2c_mst mst (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl),
    .sda_m(sda_m));
  lcd_i2c i_lcd_i2c (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rs(cmd_rs),
    .cmd_byte(cmd_byte), .addr_counter(addr_counter),
    .disp_offset(disp_offset));
  task chk(input [7:0] got, input [7:0] exp, input [127:0] what);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t %0s got %h exp %h", $time, what, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task t_badaddr;
    begin
      mst.start;
      mst.wbyte({`LCD_SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
      mst.stop;
      chk(ack, 0, "bad addr");
      $display("done t_badaddr");
    end
  endtask
  task t_fill;
    integer i;
    begin
      mst.start;
      mst.wbyte(WADR, ack);
      chk(ack, 1, "addr ack");
      mst.wbyte(8'h40, ack);
      for (i = 0; i < 33; i = i + 1) begin
        mst.wbyte(8'h41 + i[7:0], ack);
        chk(ack, i < 32, "data ack");
      end
      mst.stop;
      chk(addr_counter, 32, "fill ac");
      for (i = 0; i < 32; i = i + 1) begin
        @(negedge clk_sys);
        chk({cmd_valid, cmd_rs}, 3, "head flags");
        chk(cmd_byte, 8'h41 + i[7:0], "head byte");
        cmd_ready = 1'b1;
        @(negedge clk_sys);
        cmd_ready = 1'b0;
      end
      @(negedge clk_sys);
      chk(cmd_valid, 0, "drained");
      $display("done t_fill");
    end
  endtask
  task t_read;
    begin
      cmd_ready = 1'b1;
      mst.start;
      mst.wbyte(WADR, ack);
      mst.wbyte(8'h80, ack);
      mst.wbyte(8'h85, ack);
      chk(addr_counter, 5, "set addr");
      mst.wbyte(8'h80, ack);
      mst.wbyte(8'h1C, ack);
      chk(disp_offset, 1, "shift");
      mst.wbyte(8'h80, ack);
      mst.wbyte(8'h1C, ack);
      chk(disp_offset, 2, "shift right");
      mst.wbyte(8'h80, ack);
      mst.wbyte(8'h18, ack);
      chk(disp_offset, 1, "shift left");
      mst.wbyte(8'h80, ack);
      mst.wbyte(8'h02, ack);
      chk(addr_counter, 0, "home ac");
      chk(disp_offset, 0, "home offs");
      mst.wbyte(8'h60, ack);
      mst.start;
      mst.wbyte(RADR, ack);
      chk(ack, 1, "raddr ack");
      mst.rbyte(1'b1, rd);
      chk(rd, 8'h46, "first");
      mst.rbyte(1'b1, rd);
      chk(rd, 8'h41, "second");
      mst.rbyte(1'b0, rd);
      chk(rd, 8'h42, "third");
      mst.stop;
      chk(addr_counter, 2, "nack ac");
      mst.start;
      mst.wbyte(RADR, ack);
      mst.rbyte(1'b0, rd);
      mst.stop;
      chk(rd, 8'h42, "kept hold");
      chk(addr_counter, 2, "kept ac");
      mst.start;
      mst.wbyte(WADR, ack);
      mst.wbyte(8'h20, ack);
      mst.start;
      mst.wbyte(RADR, ack);
      mst.rbyte(1'b0, rd);
      mst.stop;
      chk(rd, 8'h02, "counter read");
      $display("done t_read");
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    cmd_ready = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk(addr_counter, 0, "reset ac");
    t_badaddr;
    t_fill;
    t_read;
    wrap_up;
  end
endmodule
